// ===== dv/smpr_host_model.sv
// Purpose: serial host side model issuing byte reads
// Assumes: go_in high one cycle per byte
// Notes:   address inverted while idle
`timescale 1ns/10ps
module smpr_host_model
   import smpr_pkg::*;
(
   // clock and reset
   input  wire logic           clk_in,
   input  wire logic           reset_n_in,
   // command
   input  wire logic           go_in,
   input  wire logic [7:0]     addr_in,
   // store byte port
   output smpr_byte_req_t      byte_req_out,
   input  wire logic [7:0]     byte_data_in,
   input  wire logic           byte_valid_in,
   input  wire logic           byte_hit_in,
   // captured answer
   output logic [31:0]         got_out,
   output logic [31:0]         n_got_out
);
   assign byte_req_out.req  = go_in;
   assign byte_req_out.addr = go_in ? addr_in : ~addr_in;
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         got_out   <= 32'h00000000;
         n_got_out <= 32'h00000000;
      end else if (byte_valid_in) begin
         got_out   <= {23'h000000, byte_hit_in, byte_data_in};
         n_got_out <= n_got_out + 32'h00000001;
      end
   end
endmodule

// ===== dv/smpr_param_rom_chk.sv
// Purpose: port assertions of the map store
// Assumes: one clock domain
// Notes:   bound from tb
`timescale 1ns/10ps
module smpr_param_rom_chk
   import smpr_pkg::*;
(
   // clock, reset and enable
   input  wire logic           clk_in,
   input  wire logic           reset_n_in,
   input  wire logic           ce_in,
   // apb
   input  wire smpr_apb_req_t  apb_req_in,
   input  wire logic           pready_out,
   input  wire logic [31:0]    prdata_out,
   input  wire logic           pslverr_out,
   // byte port
   input  wire smpr_byte_req_t byte_req_in,
   input  wire logic [7:0]     byte_data_out,
   input  wire logic           byte_valid_out,
   input  wire logic           byte_hit_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);
   logic        acc;
   logic        rd;
   logic [11:0] pa;
   logic        bv;
   assign acc = apb_req_in.psel & apb_req_in.penable & ~pready_out & ce_in;
   assign rd  = acc & ~apb_req_in.pwrite;
   assign pa  = apb_req_in.paddr;
   assign bv  = byte_valid_out;
   ////////////////////////////////////////////////////////////////////////
   property p_pready;
      pready_out |-> apb_req_in.psel && apb_req_in.penable ##1 !pready_out;
   endproperty
   a_pready: assert property (p_pready) else $error("stray pready");
   property p_mid;
      rd && pa == 12'h098 |=> pready_out && prdata_out == 32'h00037FF4;
   endproperty
   a_mid: assert property (p_mid) else $error("mid word");
   property p_small;
      rd && pa == 12'h09C |=> pready_out && prdata_out == 32'h00007FF1;
   endproperty
   a_small: assert property (p_small) else $error("small word");
   property p_hdr;
      rd && pa == 12'h0A0 |=> pready_out && prdata_out == 32'hFF0004FE;
   endproperty
   a_hdr: assert property (p_hdr) else $error("header word");
   property p_ro;
      acc && apb_req_in.pwrite && pa == 12'h098 |=> pready_out && pslverr_out;
   endproperty
   a_ro: assert property (p_ro) else $error("write not refused");
   property p_miss;
      bv && !byte_hit_out |-> byte_data_out == 8'h00;
   endproperty
   a_miss: assert property (p_miss) else $error("miss data");
   property p_range;
      bv && $past(byte_req_in.addr) > 8'hA5 |-> !byte_hit_out;
   endproperty
   a_range: assert property (p_range) else $error("range hit");
   property p_first;
      bv && byte_hit_out && $past(byte_req_in.addr) == 8'h98 |->
         byte_data_out == 8'hF4;
   endproperty
   a_first: assert property (p_first) else $error("first byte");
   property p_alt;
      bv && byte_hit_out && $past(byte_req_in.addr) == 8'hA5 |->
         byte_data_out == 8'hFF;
   endproperty
   a_alt: assert property (p_alt) else $error("alt last byte");
endmodule

// ===== dv/tb.sv
// Purpose: self-checking bench of the map store
// Assumes: ce_in held high except during the frozen-store check
// Notes:   random write data and miss addresses
`timescale 1ns/10ps
module tb
   import smpr_pkg::*;
;
   localparam logic [95:0] MAP = {32'hFF0004FE, 32'h00007FF1, 32'h00037FF4};
   logic           clk_in = 1'b0;
   logic           reset_n_in = 1'b0;
   logic           go = 1'b0;
   logic           ce = 1'b1;
   logic [7:0]     ba = 8'h00;
   smpr_apb_req_t  req = '0;
   smpr_byte_req_t breq;
   logic           pready, perr, bvalid, bhit;
   logic [31:0]    prdata, got, ngot, r, e, n;
   logic [7:0]     bdata;
   int             miscompares = 0;
   int             n_compared = 0;
   always #5 clk_in = ~clk_in;
   smpr_param_rom dut (.clk_in, .reset_n_in, .ce_in(ce), .apb_req_in(req),
      .pready_out(pready), .prdata_out(prdata), .pslverr_out(perr),
      .byte_req_in(breq), .byte_data_out(bdata), .byte_valid_out(bvalid),
      .byte_hit_out(bhit));
   smpr_host_model host (.clk_in, .reset_n_in, .go_in(go), .addr_in(ba),
      .byte_req_out(breq), .byte_data_in(bdata), .byte_valid_in(bvalid),
      .byte_hit_in(bhit), .got_out(got), .n_got_out(ngot));
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] exp_byte(input logic [7:0] a,
                                            input logic       alt);
      logic [7:0] o;
      o = a - (alt ? 8'h9A : 8'h98);
      exp_byte = (o < 8'h0C) ? {23'h000000, 1'b1, MAP[o*8 +: 8]} : 32'h0;
   endfunction
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      n_compared++;
      if (g !== x) begin
         miscompares++;
         $display("ERROR %0t got %h exp %h", $time, g, x);
      end
   endtask
   task automatic apb(input logic        w,
                      input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge clk_in) req <= '{1'b1, 1'b0, w, a, d};
      @(posedge clk_in) req.penable <= 1'b1;
      do begin
         @(posedge clk_in);
      end while (pready !== 1'b1);
      r = prdata;
      e = {31'h0, perr};
      req <= '0;
   endtask
   task automatic byt(input int a);
      @(posedge clk_in) go <= 1'b1;
      ba <= 8'(a);
      @(posedge clk_in) go <= 1'b0;
      @(posedge clk_in) #1;
   endtask
   task automatic end_of_test;
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      #100000;
      miscompares++;
      end_of_test;
   end
   initial begin
      void'($urandom(32'h8a1a9855));
      repeat (8) @(posedge clk_in);
      reset_n_in <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         apb(1'b0, 12'h098 + 12'(4 * i), $urandom);
         chk(r, MAP[i*32 +: 32]);
         apb(1'b1, 12'h098 + 12'(4 * i), $urandom);
         chk(e, 32'h1);
      end
      apb(1'b0, 12'h0C0, $urandom);
      chk({e[0], r[30:0]}, 32'h80000000);
      apb(1'b0, 12'h0B0, 32'h0);
      chk(r, 32'h2);
      for (int a = 'h96; a < 'hA6; a++) begin
         byt(a);
         chk(got, exp_byte(8'(a), 1'b0));
      end
      repeat (4) begin
         n = 32'hA6 + $urandom % 90;
         byt(n);
         chk(got, 32'h0);
      end
      apb(1'b1, 12'h0B0, 32'h3);
      for (int a = 'h96; a < 'hA8; a++) begin
         byt(a);
         chk(got, exp_byte(8'(a), 1'b1));
      end
      // a frozen store serves no byte request
      @(posedge clk_in) ce <= 1'b0;
      n = ngot;
      byt('h9A);
      @(posedge clk_in) ce <= 1'b1;
      chk(ngot, n);
      apb(1'b1, 12'h0B0, 32'h0);
      n = ngot;
      byt('h98);
      chk(ngot, n);
      // 38 bytes served, last one at A7h
      apb(1'b0, 12'h0B4, $urandom);
      chk(r, 32'h00A70026);
      end_of_test;
   end
endmodule
bind smpr_param_rom smpr_param_rom_chk u_chk (.clk_in, .reset_n_in, .ce_in,
   .apb_req_in, .pready_out, .prdata_out, .pslverr_out, .byte_req_in,
   .byte_data_out, .byte_valid_out, .byte_hit_out);

// ===== hdl/smpr_map.svh
// Purpose: offsets, field positions and fixed values of the map store
// Assumes: byte addresses on the APB side, 32-bit aligned words
// Notes:   definitions only
`ifndef SMPR_MAP_SVH
`define SMPR_MAP_SVH

// register byte addresses on APB
`define SMPR_OFS_MID_REGION    12'h098
`define SMPR_OFS_SMALL_REGION  12'h09C
`define SMPR_OFS_UNI64_HEADER  12'h0A0
`define SMPR_OFS_CTRL          12'h0B0
`define SMPR_OFS_STATUS        12'h0B4

// region descriptor fields
`define SMPR_MID_SIZE          24'h00037F
`define SMPR_SMALL_SIZE        24'h00007F
`define SMPR_RSVD_NIBBLE       4'hF
`define SMPR_ERASE_NONE        4'h0
`define SMPR_ERASE_4K          4'h1
`define SMPR_ERASE_64K         4'h2
`define SMPR_ERASE_256K        4'h4

// map header fields
`define SMPR_HDR_RSVD_BYTE     8'hFF
`define SMPR_HDR_REGION_COUNT  8'h00
`define SMPR_HDR_CONFIG_ID     8'h04
`define SMPR_HDR_RSVD_LOW      6'h3F
`define SMPR_HDR_MAP_DESC      1'h1
`define SMPR_HDR_NOT_LAST      1'h0

// byte space
`define SMPR_DISC_FIRST        8'h98
`define SMPR_DISC_LAST         8'hA3
`define SMPR_ALT_SHIFT         8'h02

// control and status fields
`define SMPR_CTRL_ALT_BIT      0
`define SMPR_CTRL_EN_BIT       1
`define SMPR_CTRL_RESET        2'h2
`define SMPR_ZERO_WORD         32'h00000000

`endif

// ===== hdl/smpr_param_rom.sv
// Purpose: read-only sector map descriptor store, apb and byte read port
// Assumes: byte requests come from logic on clk_in
// Notes on behaviour
// R1: mid region size field is 00037Fh
// R2: mid region advertises only 256KB erase
// R3: descriptor bits 7:4 read ones
// R4: small region size field is 00007Fh
// R5: small region advertises only 4KB erase
// R6: erase type four bit reads zero
// R7: uniform header top byte reads FFh
// R8: header region count 00h, config id 04h
// R9: header bit1 set, bit0 clear, 7:2 ones
// R10: dwords LSB first from discovery offset 98h
// R11: alternate space offsets are two higher
//
// The APB register port was decided locally.
`timescale 1ns/10ps
`include "smpr_map.svh"

module smpr_param_rom
   import smpr_pkg::*;
(
   // clock, reset, enable
   input  wire logic           clk_in,
   input  wire logic           reset_n_in,
   input  wire logic           ce_in,
   // apb slave
   input  wire smpr_apb_req_t  apb_req_in,
   output logic                pready_out,
   output logic [31:0]         prdata_out,
   output logic                pslverr_out,
   // byte read port
   input  wire smpr_byte_req_t byte_req_in,
   output logic [7:0]          byte_data_out,
   output logic                byte_valid_out,
   output logic                byte_hit_out
);

   ////////////////////////////////////////////////////////////////////////
   // fixed descriptor words

   localparam logic [31:0] MID_WORD = {
      `SMPR_MID_SIZE,                     // R1
      `SMPR_RSVD_NIBBLE,                  // R3
      `SMPR_ERASE_256K                    // R2 R6
   };

   localparam logic [31:0] SMALL_WORD = {
      `SMPR_SMALL_SIZE,                   // R4
      `SMPR_RSVD_NIBBLE,                  // R3
      `SMPR_ERASE_4K                      // R5 R6
   };

   localparam logic [31:0] HDR_WORD = {
      `SMPR_HDR_RSVD_BYTE,                // R7
      `SMPR_HDR_REGION_COUNT,             // R8
      `SMPR_HDR_CONFIG_ID,                // R8
      `SMPR_HDR_RSVD_LOW,                 // R9
      `SMPR_HDR_MAP_DESC,                 // R9
      `SMPR_HDR_NOT_LAST                  // R9
   };

   ////////////////////////////////////////////////////////////////////////
   // byte lookup by discovery offset

   function automatic logic [8:0] disc_byte(input logic [7:0] ofs);
      logic [7:0]  rel;
      logic [31:0] word;
      logic        hit;
      rel  = ofs - `SMPR_DISC_FIRST;
      word = `SMPR_ZERO_WORD;
      hit  = (ofs >= `SMPR_DISC_FIRST) && (ofs <= `SMPR_DISC_LAST);
      case (rel[3:2])
         2'h0: begin
            word = MID_WORD;
         end
         2'h1: begin
            word = SMALL_WORD;
         end
         2'h2: begin
            word = HDR_WORD;
         end
         default: begin
            word = `SMPR_ZERO_WORD;
         end
      endcase
      if (!hit) begin
         word = `SMPR_ZERO_WORD;
      end
      disc_byte = {hit, word[rel[1:0]*8 +: 8]};         // R10
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // state

   smpr_state_t state;
   smpr_state_t next_state;

   logic        apb_access;
   logic [7:0]  disc_addr;
   logic [8:0]  lookup;
   logic [31:0] status_word;

   assign apb_access = apb_req_in.psel && apb_req_in.penable;

   // alternate space sits two bytes above the discovery table
   assign disc_addr = state.ctrl[`SMPR_CTRL_ALT_BIT] ?
                      byte_req_in.addr - `SMPR_ALT_SHIFT :     // R11
                      byte_req_in.addr;

   assign lookup = disc_byte(disc_addr);

   assign status_word = {8'h00, state.last_addr, state.byte_count};

   ////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      next_state            = state;
      next_state.byte_valid = 1'b0;
      case (state.apb_state)
         SMPR_ST_IDLE: begin
            if (apb_access) begin
               next_state.apb_state = SMPR_ST_DONE;
               next_state.pslverr   = 1'b0;
               next_state.prdata    = `SMPR_ZERO_WORD;
               case (apb_req_in.paddr)
                  `SMPR_OFS_MID_REGION: begin
                     next_state.prdata  = MID_WORD;
                     next_state.pslverr = apb_req_in.pwrite;
                  end
                  `SMPR_OFS_SMALL_REGION: begin
                     next_state.prdata  = SMALL_WORD;
                     next_state.pslverr = apb_req_in.pwrite;
                  end
                  `SMPR_OFS_UNI64_HEADER: begin
                     next_state.prdata  = HDR_WORD;
                     next_state.pslverr = apb_req_in.pwrite;
                  end
                  `SMPR_OFS_CTRL: begin
                     next_state.prdata = {30'h00000000, state.ctrl};
                  end
                  `SMPR_OFS_STATUS: begin
                     next_state.prdata  = status_word;
                     next_state.pslverr = apb_req_in.pwrite;
                  end
                  default: begin
                     next_state.pslverr = 1'b1;
                  end
               endcase
               if (apb_req_in.pwrite) begin
                  next_state.prdata = `SMPR_ZERO_WORD;
               end
            end
         end
         SMPR_ST_DONE: begin
            next_state.apb_state = SMPR_ST_IDLE;
            // control write lands on the edge that completes the transfer
            if (apb_access && apb_req_in.pwrite &&
                (apb_req_in.paddr == `SMPR_OFS_CTRL)) begin
               next_state.ctrl = apb_req_in.pwdata[1:0];
            end
         end
         default: begin
            next_state.apb_state = SMPR_ST_IDLE;
         end
      endcase
      if (byte_req_in.req && state.ctrl[`SMPR_CTRL_EN_BIT]) begin
         next_state.byte_valid = 1'b1;
         next_state.byte_hit   = lookup[8];
         next_state.byte_data  = lookup[7:0];                  // R10 R11
         next_state.last_addr  = byte_req_in.addr;
         next_state.byte_count = state.byte_count + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registers

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state.apb_state  <= SMPR_ST_IDLE;
         state.prdata     <= `SMPR_ZERO_WORD;
         state.pslverr    <= 1'b0;
         state.ctrl       <= `SMPR_CTRL_RESET;
         state.last_addr  <= 8'h00;
         state.byte_count <= 16'h0000;
         state.byte_data  <= 8'h00;
         state.byte_valid <= 1'b0;
         state.byte_hit   <= 1'b0;
      end else if (ce_in) begin
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs

   // no answer while frozen, so the master waits for the enable
   assign pready_out     = (state.apb_state == SMPR_ST_DONE) &&
                           apb_access && ce_in;
   assign prdata_out     = state.prdata;
   assign pslverr_out    = state.pslverr && pready_out;
   assign byte_data_out  = state.byte_data;
   assign byte_valid_out = state.byte_valid;
   assign byte_hit_out   = state.byte_hit;

endmodule

// ===== hdl/smpr_pkg.sv
// Purpose: types shared by the map store
// Assumes: used with smpr_map.svh
// Notes:   all state of the top module lives in smpr_state_t
package smpr_pkg;

   // apb request from the master
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } smpr_apb_req_t;

   // byte read request from the serial side
   typedef struct packed {
      logic       req;
      logic [7:0] addr;
   } smpr_byte_req_t;

   // apb slave states
   typedef enum logic [1:0] {
      SMPR_ST_IDLE = 2'b01,
      SMPR_ST_DONE = 2'b10
   } smpr_apb_state_t;

   // whole module state
   typedef struct packed {
      smpr_apb_state_t apb_state;
      logic [31:0]     prdata;
      logic            pslverr;
      logic [1:0]      ctrl;
      logic [7:0]      last_addr;
      logic [15:0]     byte_count;
      logic [7:0]      byte_data;
      logic            byte_valid;
      logic            byte_hit;
   } smpr_state_t;

endpackage
